// ===== rtl/srb_pkg.sv
// constants, register map and types of the serial read-back and analog probe block
// assumes a 32-bit APB slave port and a bit period given in system clock cycles
package srb_pkg;
	// bus shape
	localparam int unsigned SRB_ADDR_W = 8;
	localparam int unsigned SRB_DATA_W = 32;
	// register byte offsets
	localparam logic [7:0] SRB_OFS_CTRL = 8'h00;
	localparam logic [7:0] SRB_OFS_CMD = 8'h04;
	localparam logic [7:0] SRB_OFS_RDBK = 8'h08;
	localparam logic [7:0] SRB_OFS_STAT = 8'h0C;
	localparam logic [7:0] SRB_OFS_BITP = 8'h10;
	// control register field positions
	localparam int unsigned SRB_CTRL_PTR_LSB = 0;
	localparam int unsigned SRB_CTRL_TIM_LSB = 4;
	localparam int unsigned SRB_CTRL_LOC_LSB = 8;
	// status register bit positions
	localparam int unsigned SRB_STAT_ACTIVE = 0;
	localparam int unsigned SRB_STAT_ACCEPT = 1;
	localparam int unsigned SRB_STAT_CONT = 2;
	// reset values
	localparam logic [3:0] SRB_NIB_RST = 4'h0;
	localparam logic [7:0] SRB_BITP_RST = 8'h01;
	localparam logic [7:0] SRB_BYTE_ZERO = 8'h00;
	// command codes
	localparam logic [3:0] SRB_CMD_READBACK = 4'h5;
	localparam logic [3:0] SRB_CMD_ANALOG = 4'h6;
	// read-back pointer codes
	localparam logic [3:0] SRB_PTR_CMD_PTR = 4'h3;
	localparam logic [3:0] SRB_PTR_LOC_TIM = 4'h4;
	localparam logic [3:0] SRB_PTR_NVM_ADDR = 4'h5;
	localparam logic [3:0] SRB_PTR_NVM_DATA = 4'h6;
	localparam logic [3:0] SRB_PTR_TEMP = 4'h7;
	localparam logic [3:0] SRB_PTR_BITP = 4'h8;
	localparam logic [3:0] SRB_PTR_TEST = 4'h9;
	localparam logic [3:0] SRB_PTR_PATTERN_MIN = 4'hA;
	localparam logic [7:0] SRB_COMM_PATTERN = 8'hCA;
	// analog location codes
	localparam logic [3:0] SRB_LOC_AMP_OUT = 4'h0;
	localparam logic [3:0] SRB_LOC_BRIDGE_DRIVE = 4'h1;
	localparam logic [3:0] SRB_LOC_BRIDGE_CURRENT = 4'h2;
	localparam logic [3:0] SRB_LOC_SUPPLY = 4'h3;
	localparam logic [3:0] SRB_LOC_GROUND = 4'h4;
	localparam logic [3:0] SRB_LOC_TEST_A = 4'h5;
	localparam logic [3:0] SRB_LOC_ANALOG_GROUND = 4'h6;
	localparam logic [3:0] SRB_LOC_FULL_SCALE_DAC = 4'h7;
	localparam logic [3:0] SRB_LOC_FULL_SCALE_TC_DAC = 4'h8;
	localparam logic [3:0] SRB_LOC_OFFSET_DAC = 4'h9;
	localparam logic [3:0] SRB_LOC_OFFSET_TC_DAC = 4'hA;
	localparam logic [3:0] SRB_LOC_BANDGAP = 4'hB;
	localparam logic [3:0] SRB_LOC_TEST_B = 4'hC;
	localparam logic [3:0] SRB_LOC_TEST_C = 4'hD;
	localparam logic [3:0] SRB_LOC_SENSOR_POS = 4'hE;
	localparam logic [3:0] SRB_LOC_SENSOR_NEG = 4'hF;
	// probe timing in byte times
	localparam logic [3:0] SRB_TIM_CONT = 4'hF;
	localparam logic [2:0] SRB_LAST_BIT = 3'h7;
	localparam int unsigned SRB_BYTE_CNT_W = 16;
	localparam logic [15:0] SRB_CONT_BYTES = 16'h8001;
	localparam logic [15:0] SRB_ONE_BYTE = 16'h0001;
	// probe timer states
	typedef enum logic [2:0]
	{
		SRB_T_IDLE = 3'b001,
		SRB_T_DRIVE = 3'b010,
		SRB_T_HOLD = 3'b100
	} srb_tstate_t;
endpackage

// ===== rtl/srb_probe_if.sv
// carrier between the register front end and the probe timer
// assumes both ends share clk_i
`timescale 1ns/100ps
`default_nettype none
interface srb_probe_if;
	logic start;
	logic stop;
	logic [3:0] code;
	logic [7:0] bit_period;
	logic active;
	logic accept;
	logic continuous;
	modport ctl (output start, output stop, output code, output bit_period,
		input active, input accept, input continuous);
	modport tmr (input start, input stop, input code, input bit_period,
		output active, output accept, output continuous);
endinterface
`default_nettype wire

// ===== rtl/srb_probe_timer.sv
// probe duration timer counted in serial byte times
// assumes start and stop are one-cycle pulses and bit_period is in clk_i cycles
`timescale 1ns/100ps
`default_nettype none
module srb_probe_timer
	import srb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	srb_probe_if.tmr pif
);
	srb_tstate_t st_q, st_d;
	logic [7:0] pre_q, pre_d;
	logic [2:0] bit_q, bit_d;
	logic [15:0] byte_q, byte_d;
	logic [3:0] code_q, code_d;
	logic [7:0] bp_last;
	logic [15:0] target;
	logic bit_tick;
	logic byte_tick;
	logic done;

	////////////////////////////////////////////////////////////////////////
	// byte time bookkeeping
	always_comb
	begin
		bp_last = (pif.bit_period == SRB_BYTE_ZERO) ? SRB_BYTE_ZERO : pif.bit_period - 8'h01;
		bit_tick = (pre_q == bp_last);
		byte_tick = bit_tick && (bit_q == SRB_LAST_BIT);
		target = (code_q == SRB_TIM_CONT) ? SRB_CONT_BYTES : (SRB_ONE_BYTE << code_q) + SRB_ONE_BYTE;
		done = byte_tick && (byte_q == target - SRB_ONE_BYTE);
	end

	////////////////////////////////////////////////////////////////////////
	// next state of the timer
	always_comb
	begin
		st_d = st_q;
		code_d = code_q;
		pre_d = bit_tick ? SRB_BYTE_ZERO : pre_q + 8'h01;
		bit_d = bit_tick ? bit_q + 3'h1 : bit_q;
		byte_d = byte_tick ? byte_q + SRB_ONE_BYTE : byte_q;
		case (st_q)
			SRB_T_IDLE:
			begin
				pre_d = SRB_BYTE_ZERO;
				bit_d = 3'h0;
				byte_d = 16'h0000;
			end
			SRB_T_DRIVE:
			begin
				if (done && code_q == SRB_TIM_CONT)
					st_d = SRB_T_HOLD;
				else if (done)
					st_d = SRB_T_IDLE;
			end
			SRB_T_HOLD:
			begin
				if (pif.stop)
					st_d = SRB_T_IDLE;
			end
			default:
				st_d = SRB_T_IDLE;
		endcase
		if (pif.start)
		begin
			st_d = SRB_T_DRIVE;
			code_d = pif.code;
			pre_d = SRB_BYTE_ZERO;
			bit_d = 3'h0;
			byte_d = 16'h0000;
		end
	end

	// timer registers
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_q <= SRB_T_IDLE;
			code_q <= SRB_NIB_RST;
			pre_q <= SRB_BYTE_ZERO;
			bit_q <= 3'h0;
			byte_q <= 16'h0000;
		end
		else
		begin
			st_q <= st_d;
			code_q <= code_d;
			pre_q <= pre_d;
			bit_q <= bit_d;
			byte_q <= byte_d;
		end
	end

	// status back to the front end
	assign pif.active = (st_q != SRB_T_IDLE);
	assign pif.accept = (st_q != SRB_T_DRIVE);
	assign pif.continuous = (st_q == SRB_T_HOLD);
endmodule
`default_nettype wire

// ===== rtl/srb_top.sv
// register front end of the serial read-back and analog probe block
// assumes an APB master on clk_i and inputs synchronous to clk_i
//
// Summary of operation
// - pointer 0101 returns low byte of nonvolatile memory address
// - pointer 0110 returns nonvolatile memory data byte
// - 0111 temperature index, 1000 bit period count, 1001 test data
// - pointers 1010 to 1111 return pattern 11001010 for link checks
// - timeout codes 0 to 14 drive node for two-to-code plus one bytes
// - code 1111 drives continuously; commands resume after 32,769 byte times
// - locations 0111 to 1010 select the four calibration DACs
// - other locations select amplifier, bridge, supplies, reference, inputs, test nodes
// - read-back command 0101 returns the byte the pointer selects
// - analog-read command 0110 drives selected node for timeout duration
`timescale 1ns/100ps
`default_nettype none
module srb_top
	import srb_pkg::*;
#(
	parameter int unsigned BIT_PERIOD_W = 8
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [srb_pkg::SRB_ADDR_W-1:0] paddr_i,
	input wire logic [srb_pkg::SRB_DATA_W-1:0] pwdata_i,
	output logic [srb_pkg::SRB_DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [7:0] nvm_address_i,
	input wire logic [7:0] nvm_data_byte_i,
	input wire logic [7:0] temp_index_i,
	input wire logic [7:0] test_data_i,
	output logic [7:0] readback_o,
	output logic readback_valid_o,
	output logic probe_en_o,
	output logic [3:0] probe_sel_o,
	output logic probe_is_dac_o,
	output logic cmd_accept_o
);
	// the bit period field and read-back byte are both eight bits wide
	generate
		if (BIT_PERIOD_W != 8)
		begin : g_bad_width
			$error("srb_top: BIT_PERIOD_W must be 8");
		end
	endgenerate

	srb_probe_if pif ();

	logic [3:0] ptr_q, ptr_d;
	logic [3:0] tim_q, tim_d;
	logic [3:0] loc_q, loc_d;
	logic [3:0] cmd_q, cmd_d;
	logic [7:0] bitp_q, bitp_d;
	logic [7:0] rdbk_q, rdbk_d;
	logic rdv_q, rdv_d;
	logic [3:0] sel_q, sel_d;
	logic dac_q, dac_d;
	logic en_q, en_d;
	logic acc_q, acc_d;
	logic start_q, start_d;
	logic stop_q, stop_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [SRB_DATA_W-1:0] prdata_q, prdata_d;
	logic setup_ph;
	logic commit;
	logic mapped;
	logic cmd_wr;
	logic cmd_refused;
	logic [7:0] rb_byte;
	logic [3:0] wr_cmd;

	////////////////////////////////////////////////////////////////////////
	// apb phase decode
	always_comb
	begin
		setup_ph = psel_i && penable_i && !pready_q;
		commit = psel_i && penable_i && pready_q;
		mapped = (paddr_i == SRB_OFS_CTRL) || (paddr_i == SRB_OFS_CMD) || (paddr_i == SRB_OFS_RDBK)
			|| (paddr_i == SRB_OFS_STAT) || (paddr_i == SRB_OFS_BITP);
		wr_cmd = pwdata_i[3:0];
		cmd_wr = commit && pwrite_i && (paddr_i == SRB_OFS_CMD);
		// commands during the lockout window are refused
		cmd_refused = pwrite_i && (paddr_i == SRB_OFS_CMD) && !acc_q;
	end

	////////////////////////////////////////////////////////////////////////
	// read-back byte selection
	always_comb
	begin
		case (ptr_q)
			SRB_PTR_CMD_PTR:
				rb_byte = {cmd_q, ptr_q};
			SRB_PTR_LOC_TIM:
				rb_byte = {loc_q, tim_q};
			SRB_PTR_NVM_ADDR:
				rb_byte = nvm_address_i;
			SRB_PTR_NVM_DATA:
				rb_byte = nvm_data_byte_i;
			SRB_PTR_TEMP:
				rb_byte = temp_index_i;
			SRB_PTR_BITP:
				rb_byte = bitp_q;
			SRB_PTR_TEST:
				rb_byte = test_data_i;
			default:
			begin
				if (ptr_q >= SRB_PTR_PATTERN_MIN)
					rb_byte = SRB_COMM_PATTERN;
				else
					rb_byte = SRB_BYTE_ZERO;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// apb answer: one wait state, then pready with data
	always_comb
	begin
		pready_d = setup_ph;
		pslverr_d = setup_ph && (!mapped || cmd_refused);
		prdata_d = '0;
		if (setup_ph && !pwrite_i)
		begin
			case (paddr_i)
				SRB_OFS_CTRL:
				begin
					prdata_d[SRB_CTRL_PTR_LSB +: 4] = ptr_q;
					prdata_d[SRB_CTRL_TIM_LSB +: 4] = tim_q;
					prdata_d[SRB_CTRL_LOC_LSB +: 4] = loc_q;
				end
				SRB_OFS_CMD:
					prdata_d[3:0] = cmd_q;
				SRB_OFS_RDBK:
					prdata_d[7:0] = rdbk_q;
				SRB_OFS_STAT:
				begin
					prdata_d[SRB_STAT_ACTIVE] = pif.active;
					prdata_d[SRB_STAT_ACCEPT] = pif.accept;
					prdata_d[SRB_STAT_CONT] = pif.continuous;
				end
				SRB_OFS_BITP:
					prdata_d[7:0] = bitp_q;
				default:
					prdata_d = '0;
			endcase
		end
	end

	// apb answer registers
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end
		else
		begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration nibbles and bit period
	always_comb
	begin
		ptr_d = ptr_q;
		tim_d = tim_q;
		loc_d = loc_q;
		bitp_d = bitp_q;
		if (commit && pwrite_i && paddr_i == SRB_OFS_CTRL)
		begin
			ptr_d = pwdata_i[SRB_CTRL_PTR_LSB +: 4];
			tim_d = pwdata_i[SRB_CTRL_TIM_LSB +: 4];
			loc_d = pwdata_i[SRB_CTRL_LOC_LSB +: 4];
		end
		if (commit && pwrite_i && paddr_i == SRB_OFS_BITP)
			bitp_d = pwdata_i[7:0];
	end

	// configuration registers
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ptr_q <= SRB_NIB_RST;
			tim_q <= SRB_NIB_RST;
			loc_q <= SRB_NIB_RST;
			bitp_q <= SRB_BITP_RST;
		end
		else
		begin
			ptr_q <= ptr_d;
			tim_q <= tim_d;
			loc_q <= loc_d;
			bitp_q <= bitp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command execution
	always_comb
	begin
		cmd_d = cmd_q;
		rdbk_d = rdbk_q;
		rdv_d = 1'b0;
		sel_d = sel_q;
		dac_d = dac_q;
		start_d = 1'b0;
		stop_d = 1'b0;
		if (cmd_wr && acc_q)
		begin
			cmd_d = wr_cmd;
			// any other command ends a continuous probe
			stop_d = (wr_cmd != SRB_CMD_ANALOG);
			if (wr_cmd == SRB_CMD_READBACK)
			begin
				rdbk_d = rb_byte;
				rdv_d = 1'b1;
			end
			if (wr_cmd == SRB_CMD_ANALOG)
			begin
				start_d = 1'b1;
				sel_d = loc_q;
				dac_d = (loc_q == SRB_LOC_FULL_SCALE_DAC) || (loc_q == SRB_LOC_FULL_SCALE_TC_DAC)
					|| (loc_q == SRB_LOC_OFFSET_DAC) || (loc_q == SRB_LOC_OFFSET_TC_DAC);
			end
		end
	end

	// command registers
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cmd_q <= SRB_NIB_RST;
			rdbk_q <= SRB_BYTE_ZERO;
			rdv_q <= 1'b0;
			sel_q <= SRB_LOC_AMP_OUT;
			dac_q <= 1'b0;
			start_q <= 1'b0;
			stop_q <= 1'b0;
		end
		else
		begin
			cmd_q <= cmd_d;
			rdbk_q <= rdbk_d;
			rdv_q <= rdv_d;
			sel_q <= sel_d;
			dac_q <= dac_d;
			start_q <= start_d;
			stop_q <= stop_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// probe timer and its status
	assign pif.start = start_q;
	assign pif.stop = stop_q;
	assign pif.code = tim_q;
	assign pif.bit_period = bitp_q;

	srb_probe_timer u_timer
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.pif(pif)
	);

	// probe enable and acceptance follow the timer
	always_comb
	begin
		// node chosen by sel, enable gated by timer
		en_d = pif.active || start_d || start_q; // start_q bridges the cycle before the timer runs
		acc_d = pif.accept && !start_d && !start_q;
	end

	// probe status registers
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			en_q <= 1'b0;
			acc_q <= 1'b1;
		end
		else
		begin
			en_q <= en_d;
			acc_q <= acc_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign readback_o = rdbk_q;
	assign readback_valid_o = rdv_q;
	assign probe_en_o = en_q;
	assign probe_sel_o = sel_q;
	assign probe_is_dac_o = dac_q;
	assign cmd_accept_o = acc_q;
endmodule
`default_nettype wire

// ===== bench/srb_top_properties.sv
// checker for the read-back and probe block
// assumes it is bound to srb_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module srb_top_properties
	import srb_pkg::*;
#(
	parameter int unsigned BIT_PERIOD_W = 8
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [srb_pkg::SRB_ADDR_W-1:0] paddr_i,
	input wire logic [srb_pkg::SRB_DATA_W-1:0] pwdata_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [7:0] nvm_address_i,
	input wire logic [7:0] nvm_data_byte_i,
	input wire logic [7:0] temp_index_i,
	input wire logic [7:0] test_data_i,
	input wire logic [7:0] readback_o,
	input wire logic readback_valid_o,
	input wire logic probe_en_o,
	input wire logic [3:0] probe_sel_o,
	input wire logic probe_is_dac_o,
	input wire logic cmd_accept_o
);
	logic wr, cmd5, cmd6;
	logic [11:0] ctrl_q;
	logic [7:0] bitp_q, src;
	logic [3:0] tim_l;
	logic [31:0] exp_q, dur_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////////////////////////////
	// committed writes and commands
	assign wr = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
	assign cmd5 = wr && paddr_i == SRB_OFS_CMD && pwdata_i[3:0] == SRB_CMD_READBACK;
	assign cmd6 = wr && paddr_i == SRB_OFS_CMD && pwdata_i[3:0] == SRB_CMD_ANALOG;
	// shadow of control, bit period and probe run length
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ctrl_q <= 12'h000;
			bitp_q <= SRB_BITP_RST;
			tim_l <= SRB_NIB_RST;
			exp_q <= 32'h0;
			dur_q <= 32'h0;
		end
		else
		begin
			if (wr && paddr_i == SRB_OFS_CTRL)
				ctrl_q <= pwdata_i[11:0];
			if (wr && paddr_i == SRB_OFS_BITP)
				bitp_q <= pwdata_i[7:0];
			if (cmd6)
				tim_l <= ctrl_q[7:4];
			if (cmd6)
				exp_q <= (ctrl_q[7:4] == SRB_TIM_CONT ? 32'h8001 : (32'h1 << ctrl_q[7:4]) + 32'h1) * 32'h8
					* (bitp_q == 8'h00 ? 32'h1 : 32'(bitp_q));
			dur_q <= probe_en_o ? dur_q + 32'h1 : 32'h0;
		end
	end
	// byte expected from the sources
	always_comb
	begin
		case (ctrl_q[3:0])
			SRB_PTR_NVM_ADDR: src = nvm_address_i;
			SRB_PTR_NVM_DATA: src = nvm_data_byte_i;
			SRB_PTR_TEMP: src = temp_index_i;
			SRB_PTR_BITP: src = bitp_q;
			default: src = test_data_i;
		endcase
	end
	////////////////////////////////////////////////////////////////
	property p_pready_wait;
		$rose(penable_i) && psel_i |=> pready_o;
	endproperty
	a_pready_wait: assert property (p_pready_wait) else $error("no answer after one wait state");
	property p_rb_issue;
		cmd5 |-> ##[1:2] readback_valid_o;
	endproperty
	a_rb_issue: assert property (p_rb_issue) else $error("read-back byte not issued");
	property p_rb_src;
		readback_valid_o && ctrl_q[3:0] inside {[4'h5:4'h9]} |-> readback_o == src;
	endproperty
	a_rb_src: assert property (p_rb_src) else $error("wrong read-back source");
	property p_rb_pattern;
		readback_valid_o && ctrl_q[3:0] >= SRB_PTR_PATTERN_MIN |-> readback_o == 8'hCA;
	endproperty
	a_rb_pattern: assert property (p_rb_pattern) else $error("wrong link pattern");
	property p_probe_go;
		cmd6 |-> ##[1:2] (probe_en_o && !cmd_accept_o && probe_sel_o == ctrl_q[11:8]);
	endproperty
	a_probe_go: assert property (p_probe_go) else $error("probe not started");
	property p_probe_dac;
		probe_en_o |-> probe_is_dac_o == (probe_sel_o inside {[4'h7:4'hA]});
	endproperty
	a_probe_dac: assert property (p_probe_dac) else $error("bad dac flag");
	property p_probe_len;
		$fell(probe_en_o) && tim_l != SRB_TIM_CONT |-> dur_q >= exp_q && dur_q <= exp_q + 32'h4;
	endproperty
	a_probe_len: assert property (p_probe_len) else $error("probe length wrong");
	property p_accept_back;
		$fell(probe_en_o) && tim_l != SRB_TIM_CONT |-> ##[0:3] cmd_accept_o;
	endproperty
	a_accept_back: assert property (p_accept_back) else $error("commands not resumed");
	property p_cont_hold;
		probe_en_o && !cmd_accept_o && tim_l == SRB_TIM_CONT && dur_q + 32'h4 < exp_q |=> probe_en_o && !cmd_accept_o;
	endproperty
	a_cont_hold: assert property (p_cont_hold) else $error("continuous hold broken");
	c_pattern: cover property (readback_valid_o && readback_o == 8'hCA);
	c_probe_end: cover property ($fell(probe_en_o));
	c_hold: cover property (probe_en_o && tim_l == SRB_TIM_CONT);
endmodule
bind srb_top srb_top_properties #(.BIT_PERIOD_W(BIT_PERIOD_W)) u_props (.clk_i, .rst_b_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .nvm_address_i, .nvm_data_byte_i, .temp_index_i,
	.test_data_i, .readback_o, .readback_valid_o, .probe_en_o, .probe_sel_o, .probe_is_dac_o, .cmd_accept_o);
`default_nettype wire

// ===== bench/srb_host_model.sv
// calibration host model: apb master issuing transfers
// assumes clk_i shared with the block; tasks called by the bench
`timescale 1ns/100ps
`default_nettype none
module srb_host_model
(
	input wire logic clk_i,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o
);
	// probe pin apart
	// idle bus; the host has no path to the probe output
	initial
	begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end
	// nibbles loaded as words
	// setup, access, bounded wait; error x on timeout
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (!pready_i && n < 16);
		r = prdata_i;
		e = pready_i ? pslverr_i : 1'bx;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== bench/tb_serial_readback_and_analog_probe.sv
// self-checking bench for the read-back and probe block
// assumes srb_top, the host model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_serial_readback_and_analog_probe;
	import srb_pkg::*;
	logic clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, rv, pen, dac, acc, e;
	logic [7:0] paddr, na, nd, ti, td, rb, bitp;
	logic [31:0] pwdata, prdata, r, v;
	logic [3:0] sel;
	int bad_count, checks_done, seed, n, ed;
	////////////////////////////////////////////////////////////////
	srb_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.nvm_address_i(na), .nvm_data_byte_i(nd), .temp_index_i(ti), .test_data_i(td), .readback_o(rb),
		.readback_valid_o(rv), .probe_en_o(pen), .probe_sel_o(sel), .probe_is_dac_o(dac), .cmd_accept_o(acc));
	srb_host_model host (.clk_i(clk_i), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
		.psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
	// 20 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one transfer with the expected error flag
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic x);
		host.xfer(w, a, d, r, e);
		`CHK(e, x)
		if (e === 1'bx)
			close_out;
	endtask
	// bounded wait for a level on rv (k 0), pen (k 1) or acc (k 2); c counts edges
	task automatic wait_until(input int k, input logic lv, input int lim, output int c);
		logic s;
		c = 0;
		s = (k == 0) ? rv : ((k == 1) ? pen : acc);
		while (s !== lv && c < lim)
		begin
			@(posedge clk_i);
			c++;
			s = (k == 0) ? rv : ((k == 1) ? pen : acc);
		end
		if (s !== lv)
		begin
			bad_count++;
			close_out;
		end
	endtask
	// byte that a pointer selects
	function automatic logic [7:0] exp_rb(input logic [3:0] p, input logic [7:0] lt);
		case (p)
			4'h3: return {SRB_CMD_ANALOG, p}; // command nibble is the one before, an analog read
			4'h4: return lt;
			4'h5: return na;
			4'h6: return nd;
			4'h7: return ti;
			4'h8: return bitp;
			4'h9: return td;
			4'h0, 4'h1, 4'h2: return 8'h00;
			default: return 8'hCA;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////
	// reset, registers, every pointer with random locations, hold, reset again
	initial
	begin
		seed = 32'h9F8B;
		rst_b_i = 1'b0;
		{na, nd, ti, td} = 32'h0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		`CHK({pen, acc, rb}, {1'b0, 1'b1, 8'h00})
		bus(0, SRB_OFS_BITP, 32'h0, 0);
		`CHK(r[7:0], SRB_BITP_RST)
		bus(0, SRB_OFS_STAT, 32'h0, 0);
		`CHK(r[2:0], 3'h2)
		bus(0, 8'h14, 32'h0, 1);
		`CHK(r, 32'h0)
		for (int i = 0; i < 16; i++)
		begin
			v = $random(seed);
			{na, nd, ti, td} <= v;
			bitp = 8'(i % 2 + 1);
			bus(1, SRB_OFS_BITP, 32'(bitp), 0);
			bus(1, SRB_OFS_CTRL, {20'h0, v[3:0], 4'(i % 3), 4'(i)}, 0);
			bus(1, SRB_OFS_CMD, 32'h5, 0);
			wait_until(0, 1'b1, 8, n);
			`CHK(rb, exp_rb(4'(i), {v[3:0], 4'(i % 3)}))
			bus(0, SRB_OFS_RDBK, 32'h0, 0);
			`CHK(r[7:0], exp_rb(4'(i), {v[3:0], 4'(i % 3)}))
			bus(1, SRB_OFS_CMD, 32'h6, 0);
			wait_until(1, 1'b1, 4, n);
			`CHK({sel, dac}, {v[3:0], v[3:0] inside {[4'h7:4'hA]}})
			ed = ((1 << (i % 3)) + 1) * 8 * bitp;
			wait_until(1, 1'b0, 400, n);
			`CHK(n + 1 >= ed && n + 1 <= ed + 4, 1'b1)
			wait_until(2, 1'b1, 4, n);
			`CHK(acc, 1'b1)
		end
		bus(1, SRB_OFS_CTRL, 32'hBF0, 0);
		bus(1, SRB_OFS_CMD, 32'h6, 0);
		repeat (300) @(posedge clk_i);
		`CHK({pen, acc, sel}, {1'b1, 1'b0, 4'hB})
		bus(1, SRB_OFS_CMD, 32'h5, 1);
		bus(0, SRB_OFS_STAT, 32'h0, 0);
		`CHK(r[2:0], 3'h1)
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		`CHK({pen, acc}, 2'b01)
		close_out;
	end
endmodule
`default_nettype wire
